// ==== core/timer_regs.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of the
 * sixteen-bit timer/counter.
 * Assumes a byte-wide register port addressed by the offsets below.
 */
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define ADDR_FLAG        8'h0c
`define ADDR_IRQ_ENABLE  8'h0d
`define ADDR_COUNT_LOW   8'h0e
`define ADDR_COUNT_HIGH  8'h0f
`define ADDR_CONTROL     8'h10

`define CTL_RUN          0
`define CTL_CLK_SEL      1
`define CTL_SYNC_BYPASS  2
`define CTL_OSC_EN       3
`define CTL_PS_LO        4
`define CTL_PS_HI        5
`define CTL_WIDTH        6

`define CONTROL_RESET    6'h00
`define COUNT_RESET      16'h0000
`define COUNT_MAX        16'hffff
`define INSTR_DIV        4
`define INSTR_LAST       2'h3

`endif

// ==== core/timer_pkg.sv ====
/*
 * Types shared by the timer/counter modules.
 * Assumes timer_regs.svh for the numeric constants.
 */
package timer_pkg;
    typedef enum logic [1:0] {
        ARM_IDLE      = 2'b00,
        ARM_WAIT_FALL = 2'b01,
        ARM_COUNT     = 2'b11
    } arm_state_e;

    typedef logic [1:0] prescale_code_t;
endpackage

// ==== core/sync2.sv ====
/*
 * Two-flop synchroniser for levels entering the mclk domain.
 * Assumes the input changes no faster than mclk can sample it.
 */
`timescale 1ns/10ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule // sync2

// ==== core/prescaler.sv ====
/*
 * Edge prescaler: passes every 1st, 2nd, 4th or 8th input pulse.
 * Assumes edge_in is a one-cycle pulse in the mclk domain.
 */
`timescale 1ns/10ps
module prescaler #(
    parameter int WIDTH = 3
) (
    input  wire logic                      mclk,
    input  wire logic                      rst_sync_n,
    input  wire logic                      clear,
    input  wire logic                      edge_in,
    input  wire timer_pkg::prescale_code_t code,
    output logic                           tick
);
    import timer_pkg::*;

    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] next_cnt;

    function automatic logic [WIDTH-1:0] last_of(input prescale_code_t c);
        case (c)
            2'b11:   last_of = WIDTH'(7);
            2'b10:   last_of = WIDTH'(3);
            2'b01:   last_of = WIDTH'(1);
            default: last_of = WIDTH'(0);
        endcase
    endfunction

    always_comb begin
        tick     = edge_in && (cnt >= last_of(code));
        next_cnt = cnt;
        if (clear) begin
            next_cnt = '0;
        end else if (tick) begin
            next_cnt = '0;
        end else if (edge_in) begin
            next_cnt = cnt + WIDTH'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule // prescaler

// ==== core/timer_counter.sv ====
/*
 * Sixteen-bit timer/counter with control, flag and enable registers on a
 * byte-wide register port, external count input and oscillator pin control.
 * Assumes one clock mclk (the oscillator), strobes one cycle wide and
 * compare_reset driven by logic on mclk.
 */
`timescale 1ns/10ps
`include "timer_regs.svh"
module timer_counter #(
    parameter int PS_WIDTH = 3
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    input  wire logic       compare_reset,
    input  wire logic [1:0] pin_in,
    input  wire logic [1:0] port_direction_bits,
    input  wire logic [1:0] port_out_data,
    output logic      [1:0] pin_out,
    output logic      [1:0] pin_oe,
    output logic      [1:0] port_read,
    output logic            overflow_irq
);
    import timer_pkg::*;

    logic                   rst_sync_n;
    logic [1:0]             pin_sync;
    logic [`CTL_WIDTH-1:0]  timer_control;
    logic [`CTL_WIDTH-1:0]  next_timer_control;
    logic [15:0]            count;
    logic [15:0]            next_count;
    logic                   overflow_flag;
    logic                   next_overflow_flag;
    logic                   overflow_irq_enable;
    logic                   next_overflow_irq_enable;
    logic [1:0]             instr_div;
    logic [1:0]             next_instr_div;
    logic                   src_prev;
    logic                   post_tick;
    logic                   next_post_tick;
    arm_state_e             arm_state;
    arm_state_e             next_arm_state;
    logic [7:0]             next_rdata;
    logic [1:0]             next_pin_oe;
    logic [1:0]             next_port_read;
    logic                   next_irq;
    logic                   src;
    logic                   rise;
    logic                   fall;
    logic                   run_enable;
    logic                   counter_mode;
    logic                   sync_bypass;
    logic                   osc_en;
    logic                   instr_tick;
    logic                   ps_edge;
    logic                   ps_clear;
    logic                   ps_tick;
    logic                   inc;
    logic                   wr_low;
    logic                   wr_high;
    logic                   wrap;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    sync2 #(.WIDTH(1)) u_rst_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (1'b1),
        .q     (rst_sync_n)
    );

    // external pins come from outside mclk; no logic sees the first stage
    sync2 #(.WIDTH(2)) u_pin_sync (
        .mclk  (mclk),
        .rst_n (rst_sync_n),
        .d     (pin_in),
        .q     (pin_sync)
    );

    prescaler #(.WIDTH(PS_WIDTH)) u_prescaler (
        .mclk       (mclk),
        .rst_sync_n (rst_sync_n),
        .clear      (ps_clear),
        .edge_in    (ps_edge),
        .code       (timer_control[`CTL_PS_HI:`CTL_PS_LO]),
        .tick       (ps_tick)
    );

    // decode and count path
    always_comb begin
        run_enable   = timer_control[`CTL_RUN];
        counter_mode = timer_control[`CTL_CLK_SEL];
        sync_bypass  = timer_control[`CTL_SYNC_BYPASS];
        osc_en       = timer_control[`CTL_OSC_EN];
        // crystal input pin feeds the counter while the oscillator runs
        src          = osc_en ? pin_sync[1] : pin_sync[0];
        rise         = src && !src_prev;
        fall         = !src && src_prev;
        instr_tick   = (instr_div == `INSTR_LAST);
        wr_low       = wr_stb && hit(addr, `ADDR_COUNT_LOW);
        wr_high      = wr_stb && hit(addr, `ADDR_COUNT_HIGH);
        // counter mode needs the arming fall first; timer mode is instruction cycles
        ps_edge      = run_enable && (counter_mode ?
                       (rise && arm_state == ARM_COUNT) : instr_tick);
        ps_clear     = wr_low || wr_high || !run_enable;
        // synchronised path adds one stage after the prescaler
        next_post_tick = ps_tick && counter_mode && !sync_bypass;
        if (counter_mode && !sync_bypass) begin
            inc = run_enable && post_tick;
        end else begin
            inc = run_enable && ps_tick;
        end
        wrap = inc && (count == `COUNT_MAX) && !wr_low && !wr_high && !compare_reset;
    end

    // arming state machine
    always_comb begin
        next_arm_state = arm_state;
        if (!run_enable || !counter_mode) begin
            next_arm_state = ARM_IDLE;
        end else begin
            case (arm_state)
                ARM_IDLE: begin
                    next_arm_state = fall ? ARM_COUNT : ARM_WAIT_FALL;
                end
                ARM_WAIT_FALL: begin
                    if (fall) begin
                        next_arm_state = ARM_COUNT;
                    end
                end
                ARM_COUNT: begin
                    next_arm_state = ARM_COUNT;
                end
                default: begin
                    next_arm_state = ARM_IDLE;
                end
            endcase
        end
    end

    // register and count updates
    always_comb begin
        next_timer_control       = timer_control;
        next_overflow_irq_enable = overflow_irq_enable;
        next_overflow_flag       = overflow_flag;
        next_count               = count;
        next_instr_div           = instr_div + 2'h1;
        if (wr_stb && hit(addr, `ADDR_CONTROL)) begin
            next_timer_control = wdata[`CTL_WIDTH-1:0];
        end
        if (wr_stb && hit(addr, `ADDR_IRQ_ENABLE)) begin
            next_overflow_irq_enable = wdata[0];
        end
        if (wr_stb && hit(addr, `ADDR_FLAG)) begin
            next_overflow_flag = wdata[0];
        end
        if (wrap) begin
            next_overflow_flag = 1'b1;
        end
        if (wr_low || wr_high) begin
            if (wr_low) begin
                next_count[7:0] = wdata;
            end
            if (wr_high) begin
                next_count[15:8] = wdata;
            end
        end else if (compare_reset) begin
            next_count = `COUNT_RESET;
        end else if (inc) begin
            next_count = count + 16'h0001;
        end
    end

    // read port and pin control, all registered
    always_comb begin
        next_rdata = 8'h00;
        if (rd_stb) begin
            case (addr)
                `ADDR_CONTROL:    next_rdata = {2'b00, timer_control};
                `ADDR_COUNT_LOW:  next_rdata = count[7:0];
                `ADDR_COUNT_HIGH: next_rdata = count[15:8];
                `ADDR_FLAG:       next_rdata = {7'h00, overflow_flag};
                `ADDR_IRQ_ENABLE: next_rdata = {7'h00, overflow_irq_enable};
                default:          next_rdata = 8'h00;
            endcase
        end
        // direction bit 1 means input, as for an ordinary port
        next_pin_oe    = osc_en ? 2'b00 : ~port_direction_bits;
        next_port_read = osc_en ? 2'b00 : pin_sync;
        next_irq       = overflow_flag && overflow_irq_enable;
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_control       <= `CONTROL_RESET;
            count               <= `COUNT_RESET;
            overflow_flag       <= 1'b0;
            overflow_irq_enable <= 1'b0;
            instr_div           <= 2'h0;
            src_prev            <= 1'b0;
            post_tick           <= 1'b0;
            arm_state           <= ARM_IDLE;
            rdata               <= 8'h00;
            pin_out             <= 2'h0;
            pin_oe              <= 2'h0;
            port_read           <= 2'h0;
            overflow_irq        <= 1'b0;
        end else begin
            timer_control       <= next_timer_control;
            count               <= next_count;
            overflow_flag       <= next_overflow_flag;
            overflow_irq_enable <= next_overflow_irq_enable;
            instr_div           <= next_instr_div;
            src_prev            <= src;
            post_tick           <= next_post_tick;
            arm_state           <= next_arm_state;
            rdata               <= next_rdata;
            pin_out             <= port_out_data;
            pin_oe              <= next_pin_oe;
            port_read           <= next_port_read;
            overflow_irq        <= next_irq;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_sync_n);

    a_wrap_to_zero: assert property (
        wrap |=> (count == `COUNT_RESET))
        else $error("count did not wrap to zero");

    a_overflow_sets: assert property (
        wrap |=> overflow_flag)
        else $error("overflow flag not set on wrap");

    a_flag_sticky: assert property (
        overflow_flag && !(wr_stb && addr == `ADDR_FLAG) |=> overflow_flag)
        else $error("overflow flag cleared without software");

    a_irq_gated: assert property (
        !overflow_irq_enable ##1 !overflow_irq_enable |-> !overflow_irq)
        else $error("interrupt raised while disabled");

    a_irq_raised: assert property (
        overflow_flag && overflow_irq_enable |=> overflow_irq)
        else $error("interrupt not raised for enabled overflow");

    a_timer_rate: assert property (
        run_enable && !counter_mode && inc |-> (instr_div == `INSTR_LAST))
        else $error("timer advanced outside instruction cycle");

    a_stopped_holds: assert property (
        !run_enable && !wr_low && !wr_high && !compare_reset |=> $stable(count))
        else $error("count moved while stopped");

    a_compare_clear: assert property (
        compare_reset && !wr_low && !wr_high
        |=> (count == `COUNT_RESET) && (overflow_flag == $past(overflow_flag)))
        else $error("compare reset misbehaved");

    a_write_wins: assert property (
        wr_low && compare_reset |=> (count[7:0] == $past(wdata)))
        else $error("compare reset beat a count write");

    a_osc_pins: assert property (
        osc_en |=> (pin_oe == 2'b00) && (port_read == 2'b00))
        else $error("oscillator pins not forced to inputs");

    a_arm_first: assert property (
        counter_mode && arm_state != ARM_COUNT |-> !ps_edge)
        else $error("counted before the arming fall");

    a_ctl_reserved: assert property (
        rd_stb && addr == `ADDR_CONTROL |=> (rdata[7:6] == 2'b00))
        else $error("reserved control bits read nonzero");

    a_arm_on_fall: assert property (
        counter_mode && run_enable && arm_state != ARM_COUNT && !fall
        |=> arm_state != ARM_COUNT)
        else $error("counter armed without a falling edge");

    a_async_direct: assert property (
        counter_mode && sync_bypass && ps_tick |-> inc)
        else $error("unsynchronised count did not follow the prescaler");

    a_sync_delay: assert property (
        counter_mode && !sync_bypass && ps_tick ##1 run_enable && counter_mode && !sync_bypass
        |-> inc)
        else $error("synchronised count missed its extra stage");

    a_pin_drive: assert property (
        !osc_en |=> (pin_oe == ~$past(port_direction_bits)))
        else $error("pin drive does not follow the direction bits");

    c_overflow: cover property (wrap ##1 overflow_irq);
    c_arm_fall: cover property (arm_state == ARM_WAIT_FALL && fall);
    c_compare:  cover property (compare_reset && run_enable);
    c_sync_cnt: cover property (counter_mode && !sync_bypass && inc);
    c_async:    cover property (counter_mode && sync_bypass && inc);
endmodule // timer_counter

// ==== testbench/ext_clock_source.sv ====
/*
 * Far-side model: a pulse source on the two counter pins.
 * Assumes mclk comes from the bench. Pin levels change just after rising edges.
 */
`timescale 1ns/10ps
module ext_clock_source (
    input  wire logic       mclk,
    output logic      [1:0] pin
);
    initial pin = 2'b00;

    // static levels for pin-control scenarios, with counting off
    task automatic hold(input logic [1:0] v);
        @(posedge mclk);
        pin <= v;
    endtask

    // the source stands still and low between bursts
    // half of 3 or more cycles keeps the pulses visible through the synchroniser
    task automatic burst(input int idx, input int rises, input int half);
        for (int i = 0; i < rises; i++) begin
            repeat (half) @(posedge mclk);
            pin[idx] <= 1'b1;
            repeat (half) @(posedge mclk);
            pin[idx] <= 1'b0;
        end
    endtask
endmodule // ext_clock_source

// ==== testbench/tb.sv ====
/*
 * Self-checking bench for timer_counter: register port, timer and counter modes,
 * overflow, compare reset and oscillator pin control.
 * Assumes ext_clock_source drives the pins and a 20 MHz mclk.
 */
`timescale 1ns/10ps
`include "timer_regs.svh"
module tb;
    logic       mclk;
    logic       rst_n;
    logic       wr_stb;
    logic       rd_stb;
    logic       compare_reset;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] d;
    logic [1:0] pin_in;
    logic [1:0] dir;
    logic [1:0] pout;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [1:0] port_read;
    logic       overflow_irq;
    int         n_mismatch;
    int         num_checks;

    timer_counter dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .compare_reset(compare_reset),
        .pin_in(pin_in), .port_direction_bits(dir), .port_out_data(pout),
        .pin_out(pin_out), .pin_oe(pin_oe), .port_read(port_read),
        .overflow_irq(overflow_irq));

    ext_clock_source src (.mclk(mclk), .pin(pin_in));

    always #25 mclk = ~mclk;

    task automatic complete_run;
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr   <= a;
        wdata  <= v;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rd_count(output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(`ADDR_COUNT_LOW, lo);
        rd(`ADDR_COUNT_HIGH, hi);
        v = {hi, lo};
    endtask

    task automatic set_count(input logic [15:0] v);
        wr(`ADDR_COUNT_LOW, v[7:0]);
        wr(`ADDR_COUNT_HIGH, v[15:8]);
    endtask

    task automatic in_range(input logic [15:0] v, input int lo, input int hi);
        check({15'h0000, (v >= lo && v <= hi)}, 16'h0001);
    endtask

    task automatic t_reset;
        rd(`ADDR_CONTROL, d);
        check(d, 16'h0000);
        rd(`ADDR_FLAG, d);
        check(d, 16'h0000);
        rd(8'h20, d);
        check(d, 16'h0000);
        check(pin_oe, 16'h0000);
    endtask

    task automatic t_bytes;
        logic [15:0] v;
        wr(`ADDR_CONTROL, 8'hfe);
        rd(`ADDR_CONTROL, d);
        check(d, 16'h003e);
        wr(`ADDR_CONTROL, 8'h00);
        set_count(16'ha55a);
        repeat (20) @(posedge mclk);
        rd_count(v);
        check(v, 16'ha55a);
    endtask

    task automatic t_timer;
        logic [15:0] v;
        logic [1:0]  code;
        int          n;
        for (int c = 0; c < 4; c++) begin
            code = c[1:0];
            n = 1 << c;
            set_count(16'h0000);
            // bypass bit set in one pass must change nothing in timer mode
            wr(`ADDR_CONTROL, {2'b00, code, 1'b0, (c == 0), 2'b01});
            repeat (40 * n - 2) @(posedge mclk);
            wr(`ADDR_CONTROL, 8'h00);
            rd_count(v);
            in_range(v, 9, 11);
        end
    endtask

    task automatic t_wrap;
        logic [15:0] v;
        set_count(16'hffff);
        wr(`ADDR_CONTROL, 8'h01);
        repeat (18) @(posedge mclk);
        wr(`ADDR_CONTROL, 8'h00);
        rd_count(v);
        in_range(v, 3, 6);
        rd(`ADDR_FLAG, d);
        check(d, 16'h0001);
        check(overflow_irq, 16'h0000);
        wr(`ADDR_IRQ_ENABLE, 8'h01);
        repeat (2) @(posedge mclk);
        check(overflow_irq, 16'h0001);
        wr(`ADDR_IRQ_ENABLE, 8'h00);
        repeat (2) @(posedge mclk);
        check(overflow_irq, 16'h0000);
        wr(`ADDR_FLAG, 8'h00);
        rd(`ADDR_FLAG, d);
        check(d, 16'h0000);
    endtask

    task automatic t_compare;
        logic [15:0] v;
        set_count(16'h1234);
        // counter mode with idle pins: running, yet nothing counts
        wr(`ADDR_CONTROL, 8'h03);
        @(posedge mclk);
        compare_reset <= 1'b1;
        @(posedge mclk);
        compare_reset <= 1'b0;
        rd_count(v);
        check(v, 16'h0000);
        rd(`ADDR_FLAG, d);
        check(d, 16'h0000);
        @(posedge mclk);
        addr          <= `ADDR_COUNT_LOW;
        wdata         <= 8'h77;
        wr_stb        <= 1'b1;
        compare_reset <= 1'b1;
        @(posedge mclk);
        wr_stb        <= 1'b0;
        compare_reset <= 1'b0;
        rd_count(v);
        check(v, 16'h0077);
        wr(`ADDR_CONTROL, 8'h00);
    endtask

    // pins start low, so the first rise comes before any fall and is ignored
    task automatic t_counter(input logic [7:0] ctl, input int idx, input int rises,
                             input logic [15:0] exp);
        logic [15:0] v;
        set_count(16'h0000);
        wr(`ADDR_CONTROL, ctl);
        // a read in mid-burst must give a settled, in-range value
        fork
            src.burst(idx, rises, 4);
            begin
                repeat (24) @(posedge mclk);
                rd_count(v);
                in_range(v, 0, exp);
            end
        join
        repeat (10) @(posedge mclk);
        wr(`ADDR_CONTROL, 8'h00);
        rd_count(v);
        check(v, exp);
    endtask

    task automatic t_osc;
        dir  <= 2'b00;
        pout <= 2'b11;
        // pins high, so the forced zero read is visible
        src.hold(2'b11);
        wr(`ADDR_CONTROL, 8'h08);
        repeat (3) @(posedge mclk);
        check(pin_oe, 16'h0000);
        check(port_read, 16'h0000);
        wr(`ADDR_CONTROL, 8'h00);
        repeat (3) @(posedge mclk);
        check(pin_oe, 16'h0003);
        check(pin_out, 16'h0003);
        check(port_read, 16'h0003);
        src.hold(2'b00);
        dir  <= 2'b11;
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        n_mismatch++;
        complete_run;
    end

    initial begin
        mclk          = 1'b0;
        rst_n         = 1'b0;
        wr_stb        = 1'b0;
        rd_stb        = 1'b0;
        compare_reset = 1'b0;
        addr          = 8'h00;
        wdata         = 8'h00;
        dir           = 2'b11;
        pout          = 2'b00;
        n_mismatch    = 0;
        num_checks    = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset;
        t_bytes;
        t_timer;
        t_wrap;
        t_compare;
        t_counter(8'h03, 0, 5, 16'h0004);
        t_counter(8'h07, 0, 5, 16'h0004);
        t_counter(8'h13, 0, 9, 16'h0004);
        t_counter(8'h0b, 1, 4, 16'h0003);
        t_osc;
        complete_run;
    end
endmodule // tb
